// ===== core/mifc_pkg.sv
// constants, types and register map of the motion input and feedhold block
// assumes one 200 MHz clock and an ahb-lite bus with one slave
// How it works
// - set-home edge loads preset, sets valid flag
// - input active only after full filter time
// - filter expiry gives one rising-edge event
// - override write needs per-input allow bit
// - override changes state once, inputs still win
// - input state updated once per trajectory tick
// - input rise captures positions and time within 1us
// - outputs follow software bit or chosen source
// - bridge flag follows bridge, clears on trip
// - no-trip flag low only during trip
// - error reset ored with button, soft faults only
// - no-fault flag drops on non-limit faults
// - hold ramps motion down and back up
// - held index keeps velocity and remaining distance
// - hold is level, jog only from program
// - rate disable runs index/home unscaled
// - rate percent scales speed, default 100
// - new rate percent applies at once
// - position error is command minus feedback
// - distance decimals zero to six set a read-back scale factor
// - free-running 32-bit microsecond timer for captures
package mifc_pkg;
    localparam int CLK_NS    = 5;
    localparam int USEC_NS   = 1000;
    localparam int USEC_CYC  = USEC_NS / CLK_NS;
    localparam int CAP_MAX_NS = 1000;
    localparam int CAP_MAX_CYC = CAP_MAX_NS / CLK_NS;
    localparam logic [9:0]  RATE_DEF  = 10'h064;
    localparam logic [8:0]  HOLD_FULL = 9'h100;
    localparam logic [63:0] RATE_RCP  = 64'h0000_0000_0002_8F5D;
    localparam logic [2:0]  DEC_MAX   = 3'h6;
    localparam logic [15:0] TRAJ_DEF  = 16'h00C8;
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_HOME  = 8'h04;
    localparam logic [7:0] OFS_RATE  = 8'h08;
    localparam logic [7:0] OFS_HOLDT = 8'h0C;
    localparam logic [7:0] OFS_TRAJ  = 8'h10;
    localparam logic [7:0] OFS_DEC   = 8'h14;
    localparam logic [7:0] OFS_SCALE = 8'h18;
    localparam logic [7:0] OFS_DIST  = 8'h1C;
    localparam logic [7:0] OFS_VEL   = 8'h20;
    localparam logic [7:0] OFS_ALLOW = 8'h24;
    localparam logic [7:0] OFS_OVR   = 8'h28;
    localparam logic [7:0] OFS_OSW   = 8'h2C;
    localparam logic [7:0] OFS_OASN  = 8'h30;
    localparam logic [7:0] OFS_OSEL  = 8'h34;
    localparam logic [7:0] OFS_EDGE  = 8'h38;
    localparam logic [7:0] OFS_FILT  = 8'h40;
    localparam logic [7:0] OFS_STAT  = 8'h80;
    localparam logic [7:0] OFS_CPOS  = 8'h84;
    localparam logic [7:0] OFS_PERR  = 8'h88;
    localparam logic [7:0] OFS_TIME  = 8'h8C;
    localparam logic [7:0] OFS_KPOS  = 8'h90;
    localparam logic [7:0] OFS_KMST  = 8'h94;
    localparam logic [7:0] OFS_KTIM  = 8'h98;
    localparam logic [7:0] OFS_KSRC  = 8'h9C;
    localparam logic [7:0] OFS_REM   = 8'hA0;
    localparam int C_HOME = 0, C_ERST = 1, C_RDIS = 2, C_START = 3;
    localparam int C_STOP = 4, C_KIND = 5, C_PROG = 7;
    localparam logic [1:0] K_INDEX = 2'h0, K_HOME = 2'h1;
    localparam logic [1:0] K_JOG = 2'h2, K_PROG = 2'h3;
    typedef enum logic [1:0] {MV_IDLE = 2'b00, MV_RUN = 2'b01, MV_HOLD = 2'b11} mifc_mv_e;
    typedef struct packed {
        logic hold; logic button; logic fatal; logic fault;
        logic enable; logic trip; logic bridge;
    } mifc_drv_s;
    typedef struct packed {
        logic abs_pos_valid; logic no_fault_flag; logic enabled_flag;
        logic no_trip_flag; logic bridge_on_flag;
    } mifc_flags_s;
endpackage

// ===== core/mifc_top.sv
// motion input, feedhold and drive status logic behind an ahb-lite slave
// assumes pins are asynchronous, positions come from logic on hclk
`timescale 1ns/1ps
module mifc_top import mifc_pkg::*; #(
    parameter int N_IN  = 4,
    parameter int N_OUT = 4,
    parameter int FT_W  = 16
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              clk_en,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic [N_IN-1:0]   in_pin,
    input  wire mifc_drv_s         drv_pin,
    input  wire logic [31:0]       fb_pos,
    input  wire logic [31:0]       master_pos,
    output logic      [N_OUT-1:0]  output_state,
    output mifc_flags_s            flags,
    output logic                   drive_reset_req,
    output logic      [31:0]       position_error,
    output logic      [31:0]       cmd_pos
);
    localparam int SRC_W = N_IN + 5;

    if (N_IN < 1 || N_IN > 8 || N_OUT < 1 || N_OUT > 8 || FT_W < 1 || FT_W > 32) begin : g_chk
        $error("mifc_top: N_IN/N_OUT must be 1..8, FT_W 1..32");
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // bus slave: reads are prepared in the address phase, so no wait states
    logic        wr_q, hrdy_q;
    logic [7:0]  wa_q;
    logic [31:0] hrdata_q, rd_data;
    wire         addr_ok = hsel & hready & htrans[1];
    wire  [31:0] wd = hwdata;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q     <= 1'b0;
            wa_q     <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            hrdy_q   <= 1'b1;
        end else if (clk_en) begin
            wr_q   <= addr_ok & hwrite;
            wa_q   <= haddr[7:0];
            hrdy_q <= 1'b1;
            if (addr_ok & ~hwrite)
                hrdata_q <= rd_data;
        end
    end
    assign hrdata    = hrdata_q;
    assign hreadyout = hrdy_q;
    assign hresp     = 1'b0;

    wire we      = wr_q & clk_en;
    wire w_ctrl  = we && wa_q == OFS_CTRL;
    wire w_ovr   = we && wa_q == OFS_OVR;
    wire w_edge  = we && wa_q == OFS_EDGE;
    wire w_start = w_ctrl & wd[C_START];

    // software registers
    logic [31:0] home_q, hold_t_q, dist_q, vel_q, osel_q;
    logic [9:0]  rate_q;
    logic [15:0] traj_q;
    logic [2:0]  dec_q;
    logic [N_IN-1:0]  allow_q;
    logic [N_OUT-1:0] osw_q, oasn_q;
    logic        rdis_q, home_bit_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            home_q <= '0; hold_t_q <= '0; dist_q <= '0; vel_q <= '0;
            osel_q <= '0; rate_q <= RATE_DEF; traj_q <= TRAJ_DEF;
            dec_q <= 3'h0; allow_q <= '0; osw_q <= '0; oasn_q <= '0;
            rdis_q <= 1'b0; home_bit_q <= 1'b0;
        end else if (we) begin
            case (wa_q)
                OFS_CTRL: begin
                    home_bit_q <= wd[C_HOME];
                    rdis_q     <= wd[C_RDIS];
                end
                OFS_HOME:  home_q   <= wd;
                OFS_RATE:  rate_q   <= wd[9:0];
                OFS_HOLDT: hold_t_q <= wd;
                OFS_TRAJ:  if (wd[15:0] != 16'h0000) traj_q <= wd[15:0];
                OFS_DEC:   if (wd[2:0] <= DEC_MAX && wd[31:3] == '0) dec_q <= wd[2:0];
                OFS_DIST:  dist_q   <= wd;
                OFS_VEL:   vel_q    <= wd;
                OFS_ALLOW: allow_q  <= wd[N_IN-1:0];
                OFS_OSW:   osw_q    <= wd[N_OUT-1:0];
                OFS_OASN:  oasn_q   <= wd[N_OUT-1:0];
                OFS_OSEL:  osel_q   <= wd;
                default: ;
            endcase
        end
    end
    wire home_edge = w_ctrl & wd[C_HOME] & ~home_bit_q;

    // power of ten for the chosen decimal places; only read back, no distance quantity is scaled by it
    logic [31:0] scale;
    always_comb begin
        case (dec_q)
            3'h0: scale = 32'h0000_0001;
            3'h1: scale = 32'h0000_000A;
            3'h2: scale = 32'h0000_0064;
            3'h3: scale = 32'h0000_03E8;
            3'h4: scale = 32'h0000_2710;
            3'h5: scale = 32'h0001_86A0;
            default: scale = 32'h000F_4240;
        endcase
    end

    // timebases: microsecond timer cannot be cleared by software
    logic [7:0]  pre_q;
    logic [31:0] usec_q;
    logic [15:0] tcnt_q;
    wire us_tick   = pre_q == 8'(USEC_CYC - 1);
    wire traj_tick = (tcnt_q + 16'h0001) >= traj_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q  <= 8'h00;
            usec_q <= 32'h0000_0000;
            tcnt_q <= 16'h0000;
        end else if (clk_en) begin
            pre_q  <= us_tick ? 8'h00 : pre_q + 8'h01;
            usec_q <= usec_q + {31'h0, us_tick};
            tcnt_q <= traj_tick ? 16'h0000 : tcnt_q + 16'h0001;
        end
    end

    // drive pins: three flops, a bit is taken once flops two and three agree
    mifc_drv_s d1_q, d2_q, d3_q, drv_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            d1_q <= '0; d2_q <= '0; d3_q <= '0; drv_q <= '0;
        end else if (clk_en) begin
            d1_q  <= drv_pin;
            d2_q  <= d1_q;
            d3_q  <= d2_q;
            drv_q <= (d3_q & ~(d2_q ^ d3_q)) | (drv_q & (d2_q ^ d3_q));
        end
    end

    // digital inputs: synchroniser, debounce, state, override and capture
    logic [N_IN-1:0] raw_q, deb_q, seen_q, rise_q, st_q, edge_q, cap_evt;
    logic [FT_W-1:0] ft_q [N_IN];
    for (genvar i = 0; i < N_IN; i++) begin : g_in
        logic s1_q, s2_q, s3_q;
        logic [FT_W-1:0] cnt_q;
        wire agree = s2_q == s3_q;
        wire done  = cnt_q >= ft_q[i];
        assign cap_evt[i] = agree & s3_q & ~raw_q[i];
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                s1_q <= 1'b0; s2_q <= 1'b0; s3_q <= 1'b0;
                raw_q[i] <= 1'b0; deb_q[i] <= 1'b0; rise_q[i] <= 1'b0;
                cnt_q <= '0; ft_q[i] <= '0; seen_q[i] <= 1'b0;
                st_q[i] <= 1'b0; edge_q[i] <= 1'b0;
            end else if (clk_en) begin
                s1_q <= in_pin[i];
                s2_q <= s1_q;
                s3_q <= s2_q;
                if (agree)
                    raw_q[i] <= s3_q;
                if (we && wa_q == OFS_FILT + 8'(4 * i))
                    ft_q[i] <= wd[FT_W-1:0];
                rise_q[i] <= raw_q[i] & ~deb_q[i] & done;
                if (!raw_q[i]) begin
                    cnt_q    <= '0;
                    deb_q[i] <= 1'b0;
                end else if (!deb_q[i]) begin
                    if (done)
                        deb_q[i] <= 1'b1;
                    else if (us_tick)
                        cnt_q <= cnt_q + 1'b1;
                end
                // override applies once; a later real change still gets through
                if (w_ovr && allow_q[i])
                    st_q[i] <= wd[i];
                else if (traj_tick && deb_q[i] != seen_q[i])
                    st_q[i] <= deb_q[i];
                if (traj_tick)
                    seen_q[i] <= deb_q[i];
                edge_q[i] <= rise_q[i] | (edge_q[i] & ~(w_edge & wd[i]));
            end
        end
        a_filter_edge: assert property (rise_q[i] |-> $past(raw_q[i] & ~deb_q[i] & done))
            else $error("input edge without full filter time");
        a_filter_restart: assert property (clk_en && !raw_q[i] |=> cnt_q == '0 && !deb_q[i])
            else $error("filter not restarted on drop");
        a_force_apply: assert property (w_ovr && allow_q[i] |=> st_q[i] == $past(wd[i]))
            else $error("allowed override did not set input");
        a_force_block: assert property (w_ovr && !allow_q[i] && !traj_tick |=> st_q[i] == $past(st_q[i]))
            else $error("override took effect without allow");
    end

    // capture from the synchroniser edge: three cycles, well under the bound
    logic [31:0] kpos_q, kmst_q, ktim_q;
    logic [3:0]  ksrc_q, src_n;
    logic        kval_q;
    always_comb begin
        src_n = 4'h0;
        for (int k = N_IN - 1; k >= 0; k--)
            if (cap_evt[k])
                src_n = 4'(k);
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kpos_q <= '0; kmst_q <= '0; ktim_q <= '0;
            ksrc_q <= 4'h0; kval_q <= 1'b0;
        end else if (clk_en && |cap_evt) begin
            kpos_q <= fb_pos;
            kmst_q <= master_pos;
            ktim_q <= usec_q;
            ksrc_q <= src_n;
            kval_q <= 1'b1;
        end
    end
    a_cap_time: assert property (clk_en && |cap_evt |=> ktim_q == $past(usec_q) && kpos_q == $past(fb_pos))
        else $error("capture missed timer or position");

    // drive status and error reset
    logic fault_lat_q, fatal_lat_q, rst_q;
    mifc_flags_s flags_q;
    wire rst_req   = (w_ctrl & wd[C_ERST]) | drv_q.button;
    wire fault_lat = drv_q.fault | (fault_lat_q & ~rst_req);
    wire fatal_lat = drv_q.fatal | fatal_lat_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_lat_q <= 1'b0; fatal_lat_q <= 1'b0; rst_q <= 1'b0;
            flags_q <= '0;
        end else if (clk_en) begin
            fault_lat_q <= fault_lat;
            fatal_lat_q <= fatal_lat;
            rst_q       <= rst_req;
            flags_q.bridge_on_flag <= drv_q.bridge & ~drv_q.trip;
            flags_q.no_trip_flag   <= ~drv_q.trip;
            flags_q.enabled_flag   <= drv_q.enable;
            flags_q.no_fault_flag  <= ~(fault_lat | fatal_lat);
            if (home_edge)
                flags_q.abs_pos_valid <= 1'b1;
        end
    end
    assign flags           = flags_q;
    assign drive_reset_req = rst_q;
    a_bridge_trip: assert property (clk_en && drv_q.trip |=> !flags_q.bridge_on_flag && !flags_q.no_trip_flag)
        else $error("bridge flag set during trip");
    a_fault_drop: assert property (clk_en && drv_q.fault |=> !flags_q.no_fault_flag)
        else $error("no-fault flag kept during fault");

    // digital outputs
    logic [N_OUT-1:0] out_q;
    wire  [SRC_W-1:0] src = {flags_q, st_q};
    for (genvar j = 0; j < N_OUT; j++) begin : g_out
        wire [3:0] sel = osel_q[4*j +: 4];
        wire       pick = (32'(sel) < SRC_W) ? src[sel] : 1'b0;
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn)
                out_q[j] <= 1'b0;
            else if (clk_en)
                out_q[j] <= oasn_q[j] ? pick : osw_q[j];
        end
    end
    assign output_state = out_q;

    // feedhold ramp: 256 steps spread over the hold time in microseconds, step period counted in clock cycles so short times stay accurate
    mifc_mv_e    mv_q;
    logic [1:0]  kind_q;
    logic        prog_q;
    logic [8:0]  lvl_q;
    logic [39:0] hcnt_q;
    wire [39:0] hper  = ({8'h00, hold_t_q} * 40'(USEC_CYC)) >> 8;
    wire        jump  = hold_t_q == 32'h0;
    wire        hstep = jump | ((hcnt_q + 40'h1) >= hper);
    wire        hold_apply = drv_q.hold && mv_q != MV_IDLE && (kind_q != K_JOG || prog_q);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lvl_q  <= HOLD_FULL;
            hcnt_q <= 40'h0;
        end else if (clk_en) begin
            hcnt_q <= hstep ? 40'h0 : hcnt_q + 40'h1;
            if (hold_apply) begin
                if (lvl_q != 9'h0 && hstep)
                    lvl_q <= jump ? 9'h0 : lvl_q - 9'h1;
            end else if (lvl_q != HOLD_FULL && hstep)
                lvl_q <= jump ? HOLD_FULL : lvl_q + 9'h1;
        end
    end
    a_hold_down: assert property (clk_en && hold_apply |=> lvl_q <= $past(lvl_q))
        else $error("motion level rose during hold");

    // rate scaling: step = vel * pct * level / 25600, via a reciprocal rounded up so 100% is exact
    wire        scaled = !(rdis_q && (kind_q == K_INDEX || kind_q == K_HOME));
    wire [9:0]  pct    = scaled ? rate_q : RATE_DEF;
    wire [63:0] prod   = 64'(vel_q[23:0]) * 64'(pct) * 64'(lvl_q) * RATE_RCP;
    wire [31:0] step   = prod[63:32];
    logic [31:0] rem_q, cpos_q, perr_q;
    wire        jog    = kind_q == K_JOG;
    wire [31:0] use_st = (jog || step < rem_q) ? step : rem_q;

    // motion: index/home/program consume distance, jog runs until stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mv_q <= MV_IDLE; kind_q <= K_INDEX; prog_q <= 1'b0;
            rem_q <= '0; cpos_q <= '0; perr_q <= '0;
        end else if (clk_en) begin
            perr_q <= cpos_q - fb_pos;
            if (w_start) begin
                mv_q   <= MV_RUN;
                kind_q <= wd[C_KIND +: 2];
                prog_q <= wd[C_PROG];
                rem_q  <= dist_q;
            end else if (w_ctrl && wd[C_STOP]) begin
                mv_q <= MV_IDLE;
            end else if (mv_q != MV_IDLE && traj_tick) begin
                if (!jog)
                    rem_q <= rem_q - use_st;
                if (!jog && use_st == rem_q)
                    mv_q <= MV_IDLE;
                else if (hold_apply && lvl_q == 9'h0)
                    mv_q <= MV_HOLD;
                else
                    mv_q <= MV_RUN;
            end
            if (home_edge)
                cpos_q <= home_q;
            else if (mv_q != MV_IDLE && traj_tick && !w_start && !(w_ctrl && wd[C_STOP]))
                cpos_q <= vel_q[31] ? cpos_q - use_st : cpos_q + use_st;
        end
    end
    assign cmd_pos        = cpos_q;
    assign position_error = perr_q;

    a_home_load: assert property (home_edge |=> cpos_q == $past(home_q) && flags_q.abs_pos_valid)
        else $error("set-home did not load position");
    a_hold_keep: assert property (clk_en && mv_q == MV_HOLD && lvl_q == 9'h0 && !w_ctrl |=> rem_q == $past(rem_q))
        else $error("held index lost distance");
    a_rate_unity: assert property (!scaled && lvl_q == HOLD_FULL && vel_q[23:16] == 8'h00
        |-> step == 32'(vel_q[23:0]))
        else $error("rate scaling applied while disabled");
    a_pos_error: assert property (clk_en |=> perr_q == $past(cpos_q) - $past(fb_pos))
        else $error("position error wrong");
    a_timer_step: assert property (clk_en && us_tick |=> usec_q == $past(usec_q) + 32'h1)
        else $error("timer did not advance");
    a_dec_range: assert property (dec_q <= DEC_MAX)
        else $error("decimal places out of range");

    // read multiplexer
    always_comb begin
        rd_data = 32'h0000_0000;
        case (haddr[7:0])
            OFS_CTRL:  rd_data = {29'h0, rdis_q, 1'b0, home_bit_q};
            OFS_HOME:  rd_data = home_q;
            OFS_RATE:  rd_data = {22'h0, rate_q};
            OFS_HOLDT: rd_data = hold_t_q;
            OFS_TRAJ:  rd_data = {16'h0, traj_q};
            OFS_DEC:   rd_data = {29'h0, dec_q};
            OFS_SCALE: rd_data = scale;
            OFS_DIST:  rd_data = dist_q;
            OFS_VEL:   rd_data = vel_q;
            OFS_ALLOW: rd_data = 32'(allow_q);
            OFS_OVR:   rd_data = 32'(st_q);
            OFS_OSW:   rd_data = 32'(osw_q);
            OFS_OASN:  rd_data = 32'(oasn_q);
            OFS_OSEL:  rd_data = osel_q;
            OFS_EDGE:  rd_data = 32'(edge_q);
            OFS_STAT:  rd_data = {16'h0, mv_q, kval_q, flags_q, 8'(st_q)};
            OFS_CPOS:  rd_data = cpos_q;
            OFS_PERR:  rd_data = perr_q;
            OFS_TIME:  rd_data = usec_q;
            OFS_KPOS:  rd_data = kpos_q;
            OFS_KMST:  rd_data = kmst_q;
            OFS_KTIM:  rd_data = ktim_q;
            OFS_KSRC:  rd_data = {28'h0, ksrc_q};
            OFS_REM:   rd_data = rem_q;
            default: begin
                for (int f = 0; f < N_IN; f++)
                    if (haddr[7:0] == OFS_FILT + 8'(4 * f))
                        rd_data = 32'(ft_q[f]);
            end
        endcase
    end
endmodule

// ===== test/mifc_far.sv
// far-side model: power drive pins, input switches and feedback encoders
// assumes the bench sets the pin levels that it wants through drv_set and in_set
`timescale 1ns/1ps
module mifc_far import mifc_pkg::*; (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire mifc_drv_s   drv_set,
    input  wire logic [3:0]  in_set,
    input  wire logic [31:0] cmd_pos,
    output mifc_drv_s        drv_pin,
    output logic      [3:0]  in_pin,
    output logic      [31:0] fb_pos,
    output logic      [31:0] master_pos
);
    // feedback trails the command by a fixed offset so the expected error is known
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fb_pos     <= 32'h0;
            master_pos <= 32'h0;
        end else begin
            fb_pos     <= cmd_pos - 32'h10;
            master_pos <= master_pos + 32'h1;
        end
    end
    assign drv_pin = drv_set;
    assign in_pin  = in_set;
endmodule

// ===== test/testbench.sv
// self-checking bench: ahb-lite master tasks and register/port checks
// assumes a single slave with zero wait states and the far-side model in mifc_far
`timescale 1ns/1ps
module testbench;
    import mifc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, drive_reset_req;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, fb_pos, master_pos, position_error, cmd_pos, rv, t0;
    logic [3:0] in_set, in_pin, output_state;
    mifc_drv_s drv_set, drv_pin;
    mifc_flags_s flags;
    int miscompares = 0;
    int tests_run = 0;
    mifc_top dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .in_pin(in_pin), .drv_pin(drv_pin), .fb_pos(fb_pos),
        .master_pos(master_pos), .output_state(output_state), .flags(flags),
        .drive_reset_req(drive_reset_req), .position_error(position_error), .cmd_pos(cmd_pos));
    mifc_far far (.hclk(hclk), .hresetn(hresetn), .drv_set(drv_set), .in_set(in_set), .cmd_pos(cmd_pos),
        .drv_pin(drv_pin), .in_pin(in_pin), .fb_pos(fb_pos), .master_pos(master_pos));
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rv, exp);
    endtask
    // command position gain over exactly ten trajectory ticks (period 4)
    task automatic rate_chk(input logic [31:0] exp);
        xfer(OFS_CPOS, 1'b0, 32'h0);
        t0 = rv;
        repeat (37) @(posedge hclk);
        xfer(OFS_CPOS, 1'b0, 32'h0);
        chk(rv - t0, exp);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    initial begin
        #200us;
        miscompares++;
        close_out();
    end
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        in_set  = 4'h0;
        drv_set = '0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(OFS_RATE, 32'h64);
        xfer(OFS_RATE, 1'b1, 32'hC8);
        rdchk(OFS_RATE, 32'hC8);
        xfer(OFS_HOME, 1'b1, 32'h1234);
        xfer(OFS_CTRL, 1'b1, 32'h1);
        repeat (6) @(posedge hclk);
        chk(cmd_pos, 32'h1234);
        chk({31'h0, flags.abs_pos_valid}, 32'h1);
        chk(position_error, 32'h10);
        xfer(OFS_DEC, 1'b1, 32'h6);
        xfer(OFS_DEC, 1'b1, 32'h7);
        rdchk(OFS_DEC, 32'h6);
        rdchk(OFS_SCALE, 32'hF4240);
        // out0 from its software bit, out1 follows source 4 (bridge flag)
        xfer(OFS_OSW, 1'b1, 32'h1);
        xfer(OFS_OSEL, 1'b1, 32'h40);
        xfer(OFS_OASN, 1'b1, 32'h2);
        drv_set <= 7'h03;
        repeat (8) @(posedge hclk);
        chk({28'h0, output_state}, 32'h1);
        drv_set <= 7'h05;
        repeat (8) @(posedge hclk);
        chk({27'h0, flags}, 32'h1F);
        chk({28'h0, output_state}, 32'h3);
        drv_set <= 7'h17;
        repeat (8) @(posedge hclk);
        chk({27'h0, flags}, 32'h14);
        drv_set <= 7'h20;
        repeat (8) @(posedge hclk);
        chk({31'h0, drive_reset_req}, 32'h1);
        drv_set <= 7'h00;
        xfer(OFS_TRAJ, 1'b1, 32'h4);
        xfer(OFS_FILT, 1'b1, 32'h2);
        // a pulse shorter than the filter time must leave no edge behind
        in_set <= 4'h1;
        repeat (200) @(posedge hclk);
        in_set <= 4'h0;
        rdchk(OFS_EDGE, 32'h0);
        rdchk(OFS_KSRC, 32'h0);
        rdchk(OFS_KPOS, 32'h1224);
        in_set <= 4'h1;
        repeat (800) @(posedge hclk);
        rdchk(OFS_EDGE, 32'h1);
        rdchk(OFS_OVR, 32'h1);
        xfer(OFS_OVR, 1'b1, 32'h0);
        repeat (20) @(posedge hclk);
        rdchk(OFS_OVR, 32'h1);
        xfer(OFS_ALLOW, 1'b1, 32'h1);
        xfer(OFS_OVR, 1'b1, 32'h0);
        repeat (20) @(posedge hclk);
        rdchk(OFS_OVR, 32'h0);
        in_set <= 4'h0;
        repeat (20) @(posedge hclk);
        in_set <= 4'h1;
        repeat (800) @(posedge hclk);
        rdchk(OFS_OVR, 32'h1);
        xfer(OFS_TIME, 1'b0, 32'h0);
        t0 = rv;
        repeat (1000) @(posedge hclk);
        xfer(OFS_TIME, 1'b0, 32'h0);
        chk({31'h0, (rv - t0 >= 32'h5) && (rv - t0 <= 32'h6)}, 32'h1);
        // index of 0x8000 at velocity 16 per tick (32 at the 200% rate set earlier); home bit kept high so no new set-home edge
        xfer(OFS_VEL, 1'b1, 32'h10);
        xfer(OFS_DIST, 1'b1, 32'h8000);
        xfer(OFS_HOLDT, 1'b1, 32'h4);
        xfer(OFS_CTRL, 1'b1, 32'h9);
        rate_chk(32'h140);
        xfer(OFS_RATE, 1'b1, 32'h32);
        rate_chk(32'h50);
        xfer(OFS_CTRL, 1'b1, 32'h5);
        rate_chk(32'hA0);
        drv_set <= 7'h40;
        repeat (1000) @(posedge hclk);
        rate_chk(32'h0);
        xfer(OFS_STAT, 1'b0, 32'h0);
        chk({30'h0, rv[15:14]}, 32'h3);
        drv_set <= 7'h00;
        repeat (10000) @(posedge hclk);
        rdchk(OFS_CPOS, 32'h9234);
        rdchk(OFS_REM, 32'h0);
        // a plain jog ignores the hold, a jog started from a program obeys it
        drv_set <= 7'h40;
        xfer(OFS_CTRL, 1'b1, 32'h49);
        repeat (1000) @(posedge hclk);
        rate_chk(32'h50);
        xfer(OFS_CTRL, 1'b1, 32'hC9);
        repeat (1000) @(posedge hclk);
        rate_chk(32'h0);
        chk({31'h0, hresp}, 32'h0);
        close_out();
    end
endmodule
